// File: watchdog_regs.svh
// Register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

// Register offsets (8-bit special function register space)
`define WDT_CTL_ADDR      8'h9F
`define SYS_CTL_ADDR      8'hBF
`define IRQ_STAT_ADDR     8'hE1
`define IRQ_MASK_ADDR     8'hE2

// Watchdog control fields
`define WDT_EN_BIT        7
`define WDT_CLR_BIT       5
`define WDT_DIV_MSB       2
`define WDT_DIV_LSB       0

// System control fields
`define SYS_WDR_BIT       7
`define SYS_ISP_BIT       2
`define SYS_LATCH_STROBE_INHIBIT_BIT      0

// Interrupt status fields
`define IRQ_OVF_BIT       0
`define IRQ_HALF_BIT      1

// Reset values
`define WDT_CNT_RST       16'h0000
`define WDT_DIV_RST       3'h0
`define IRQ_RST           2'h0

// Counter and divider
`define WDT_CNT_MAX       16'hFFFF
`define WDT_DIV_BASE      10'h008

// Timing: a 100 ns (10 MHz) oscillator period, and timeout figures at a 40 MHz oscillator
`define OSC_PERIOD_NS     100
`define WDT_TMO_MIN_MS    13.11
`define WDT_TMO_MAX_MS    1677.72
`define WDT_TMO_MIN_CYC   (8 * 65536)
`define WDT_TMO_MAX_CYC   (1024 * 65536)

// Chip reset pulse length in clocks, and last count of the address latch strobe half period
`define CHIP_RST_CYCLES   3'h4
`define ALE_HALF_LAST     2'h2

`endif

// File: watchdog_pkg.sv
// Types shared by the watchdog block
package watchdog_pkg;

   typedef struct packed {
      logic [15:0] wdt_cnt;
      logic [9:0]  pre_cnt;
      logic        wdt_en;
      logic [2:0]  div_sel;
      logic        wdt_flag;
      logic        isp_en;
      logic        ale_inh;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_mask;
      logic [7:0]  rd_data;
      logic        irq;
      logic [2:0]  rst_cnt;
      logic        chip_rst;
      logic [1:0]  ale_div;
      logic        ale;
   } wdt_state_t;

endpackage : watchdog_pkg

// File: watchdog_reset_timer.sv
// Watchdog reset timer with system control bits and interrupt status
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "watchdog_regs.svh"

//Contract
// - A 16-bit count advances on each divided tick and overflows into chip reset.
// - Writing one to control bit 7 starts counting with the selected divider.
// - Any reset, external or from overflow, forces the enable bit to zero.
// - Writing one to control bit 5 zeroes the count, restarting from zero.
// - Divider field bits 2..0 divide the oscillator by 8 up to 1024.
// - Timeout is a full 16-bit count of divided ticks.
// - Overflow reset sets the watchdog reset flag, system control bit 7.
// - System control bit 0 suppresses the oscillator/6 clock on the latch pin.
// - System control bit 2 enables the in-system programming function.
module watchdog_reset_timer #(
   parameter logic [15:0] CNT_MAX = `WDT_CNT_MAX
) (
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       resetn_in,
   // Register port
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic       wr_strobe_in,
   input  wire logic       rd_strobe_in,
   output logic      [7:0] rd_data_out,
   // Chip level outputs
   output logic            chip_reset_out,
   output logic            ale_out,
   output logic            isp_enable_out,
   output logic            irq_out
);
   import watchdog_pkg::*;

   wdt_state_t st_r;
   wdt_state_t st_nxt;
   logic       rst_meta_r;
   logic       rst_sync_r;

   logic       wr_wdt;
   logic       wr_sys;
   logic       wr_mask;
   logic       rd_stat;
   logic       tick;
   logic       ovf;
   logic       half;
   logic       clr;
   logic [1:0] ev;
   logic [1:0] stat_nxt;

   // Last prescaler value for a divider code: 8 << code, minus one
   function automatic logic [9:0] div_last(input logic [2:0] sel);
      div_last = (`WDT_DIV_BASE << sel) - 10'h001;
   endfunction : div_last

   // Reset release through two flops; only the second is used
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   assign wr_wdt  = wr_strobe_in && (addr_in == `WDT_CTL_ADDR);
   assign wr_sys  = wr_strobe_in && (addr_in == `SYS_CTL_ADDR);
   assign wr_mask = wr_strobe_in && (addr_in == `IRQ_MASK_ADDR);
   assign rd_stat = rd_strobe_in && (addr_in == `IRQ_STAT_ADDR);
   assign clr     = wr_wdt && wr_data_in[`WDT_CLR_BIT];

   // Divided time base; the prescaler only runs while enabled.
   // Compare with >= so a smaller divider written mid-count wraps at once
   // instead of running the prescaler all the way round.
   assign tick = st_r.wdt_en && (st_r.pre_cnt >= div_last(st_r.div_sel));
   // A clear in the same cycle wins over the overflow
   assign ovf  = tick && (st_r.wdt_cnt == CNT_MAX) && !clr;
   assign half = tick && (st_r.wdt_cnt == (CNT_MAX >> 1)) && !clr;

   assign ev[`IRQ_OVF_BIT]  = ovf;
   assign ev[`IRQ_HALF_BIT] = half;

   // One sticky bit per event; a read clears, an event in the same cycle wins
   generate
      for (genvar i = 0; i < 2; i++) begin : g_stat
         assign stat_nxt[i] = ev[i] | (st_r.irq_stat[i] & !rd_stat);
      end
   endgenerate

   always_comb begin
      st_nxt = st_r;

      // Counter and prescaler
      if (tick) begin
         st_nxt.pre_cnt = 10'h000;
         st_nxt.wdt_cnt = st_r.wdt_cnt + 16'h0001;
      end else if (st_r.wdt_en) begin
         st_nxt.pre_cnt = st_r.pre_cnt + 10'h001;
      end

      // Control register writes; clear is a strobe, never stored
      if (wr_wdt) begin
         st_nxt.wdt_en  = wr_data_in[`WDT_EN_BIT];
         st_nxt.div_sel = wr_data_in[`WDT_DIV_MSB:`WDT_DIV_LSB];
         if (clr) begin
            st_nxt.wdt_cnt = `WDT_CNT_RST;
            st_nxt.pre_cnt = 10'h000;
         end
      end
      if (wr_sys) begin
         st_nxt.isp_en   = wr_data_in[`SYS_ISP_BIT];
         st_nxt.ale_inh  = wr_data_in[`SYS_LATCH_STROBE_INHIBIT_BIT];
         st_nxt.wdt_flag = st_r.wdt_flag & wr_data_in[`SYS_WDR_BIT];
      end
      if (wr_mask) begin
         st_nxt.irq_mask = wr_data_in[1:0];
      end

      // Overflow: chip reset, enable dropped, flag set; beats any write but a clear, which suppresses it
      if (ovf) begin
         st_nxt.wdt_en   = 1'b0;
         st_nxt.wdt_cnt  = `WDT_CNT_RST;
         st_nxt.pre_cnt  = 10'h000;
         st_nxt.wdt_flag = 1'b1;
         st_nxt.chip_rst = 1'b1;
         st_nxt.rst_cnt  = `CHIP_RST_CYCLES - 3'h1;
      end else if (st_r.rst_cnt != 3'h0) begin
         st_nxt.rst_cnt = st_r.rst_cnt - 3'h1;
      end else begin
         st_nxt.chip_rst = 1'b0;
      end
      // Enable held low while the chip reset pulse is out
      if (st_r.chip_rst) begin
         st_nxt.wdt_en = 1'b0;
      end

      // Sticky status: read clears, a new event in the same cycle wins
      st_nxt.irq_stat = stat_nxt;
      st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_mask);

      // Read data stands only in the cycle after the strobe
      st_nxt.rd_data = 8'h00;
      if (rd_strobe_in) begin
         case (addr_in)
            `WDT_CTL_ADDR: begin
               st_nxt.rd_data[`WDT_EN_BIT] = st_r.wdt_en;
               st_nxt.rd_data[`WDT_DIV_MSB:`WDT_DIV_LSB] = st_r.div_sel;
            end
            `SYS_CTL_ADDR: begin
               st_nxt.rd_data[`SYS_WDR_BIT]  = st_r.wdt_flag;
               st_nxt.rd_data[`SYS_ISP_BIT]  = st_r.isp_en;
               st_nxt.rd_data[`SYS_LATCH_STROBE_INHIBIT_BIT] = st_r.ale_inh;
            end
            `IRQ_STAT_ADDR: begin
               st_nxt.rd_data[1:0] = st_r.irq_stat;
            end
            `IRQ_MASK_ADDR: begin
               st_nxt.rd_data[1:0] = st_r.irq_mask;
            end
            default: begin
               st_nxt.rd_data = 8'h00;
            end
         endcase
      end

      // Oscillator/6 on the latch pin: toggle every third clock unless inhibited
      if (st_r.ale_div == `ALE_HALF_LAST) begin
         st_nxt.ale_div = 2'h0;
         st_nxt.ale     = !st_r.ale;
      end else begin
         st_nxt.ale_div = st_r.ale_div + 2'h1;
      end
      if (st_r.ale_inh) begin
         st_nxt.ale = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data_out    = st_r.rd_data;
   assign chip_reset_out = st_r.chip_rst;
   assign ale_out        = st_r.ale;
   assign isp_enable_out = st_r.isp_en;
   assign irq_out        = st_r.irq;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_sync_r);

   chk_overflow_reset: assert property (
      ovf |=> chip_reset_out && !st_r.wdt_en && (st_r.wdt_cnt == 16'h0000))
      else $error("overflow did not raise chip reset");

   chk_enable_start: assert property (
      wr_wdt && wr_data_in[`WDT_EN_BIT] && !ovf && !st_r.chip_rst |=> st_r.wdt_en)
      else $error("enable write did not start watchdog");

   chk_enable_forced: assert property (
      chip_reset_out |-> !st_r.wdt_en)
      else $error("enable set during watchdog reset");

   chk_clear_zero: assert property (
      clr |=> st_r.wdt_cnt == 16'h0000 && st_r.pre_cnt == 10'h000)
      else $error("clear did not zero counter");

   chk_tick_step: assert property (
      st_r.wdt_en && !tick && !wr_wdt |=> st_r.pre_cnt == $past(st_r.pre_cnt) + 10'h001)
      else $error("prescaler did not advance");

   chk_count_step: assert property (
      st_r.wdt_en && !tick && !wr_wdt |=> $stable(st_r.wdt_cnt))
      else $error("counter moved without a divided tick");

   chk_flag_set: assert property (
      $rose(chip_reset_out) |-> st_r.wdt_flag)
      else $error("watchdog reset flag not set");

   chk_ale_quiet: assert property (
      st_r.ale_inh |=> !ale_out)
      else $error("latch clock not inhibited");

   chk_isp_write: assert property (
      wr_sys |=> isp_enable_out == $past(wr_data_in[`SYS_ISP_BIT]))
      else $error("isp enable not written");

   chk_unused_zero: assert property (
      rd_strobe_in && addr_in == `WDT_CTL_ADDR |=> rd_data_out[6:3] == 4'h0)
      else $error("unused control bits read nonzero");

   chk_irq_level: assert property (
      st_r.irq_stat[0] && st_r.irq_mask[0] && !rd_stat && !wr_mask |=> irq_out)
      else $error("masked interrupt not raised");

   chk_irq_quiet: assert property (
      (st_r.irq_stat & st_r.irq_mask) == 2'h0 && ev == 2'h0 && !wr_mask |=> !irq_out)
      else $error("interrupt raised with nothing pending");

   chk_mask_write: assert property (
      wr_mask |=> st_r.irq_mask == $past(wr_data_in[1:0]))
      else $error("mask write not stored");

   chk_stat_sticky: assert property (
      st_r.irq_stat[0] && !rd_stat |=> st_r.irq_stat[0])
      else $error("overflow status lost without a read");

   chk_stat_clear: assert property (
      rd_stat && !ovf && !half |=> st_r.irq_stat == 2'h0)
      else $error("status read did not clear");

   chk_half_event: assert property (
      half |=> st_r.irq_stat[`IRQ_HALF_BIT])
      else $error("half-way event not recorded");

   chk_ovf_flag: assert property (
      ovf |=> st_r.wdt_flag && st_r.irq_stat[`IRQ_OVF_BIT])
      else $error("overflow did not set flag and status");

   chk_flag_sticky: assert property (
      !ovf && !wr_sys |=> $stable(st_r.wdt_flag))
      else $error("reset flag changed on its own");

   chk_flag_clear: assert property (
      wr_sys && !wr_data_in[`SYS_WDR_BIT] && !ovf |=> !st_r.wdt_flag)
      else $error("reset flag not cleared by write");

   chk_pulse_len: assert property (
      $rose(chip_reset_out) |-> chip_reset_out [*4] ##1 !chip_reset_out)
      else $error("chip reset pulse length wrong");

   chk_pulse_cause: assert property (
      $rose(chip_reset_out) |-> $past(ovf))
      else $error("chip reset without overflow");

   chk_count_tick: assert property (
      tick && !clr && !ovf |=> st_r.wdt_cnt == $past(st_r.wdt_cnt) + 16'h0001)
      else $error("counter did not advance on tick");

   chk_count_still: assert property (
      !st_r.wdt_en && !clr |=> $stable(st_r.wdt_cnt))
      else $error("counter moved while disabled");

   chk_pre_still: assert property (
      !st_r.wdt_en && !clr |=> $stable(st_r.pre_cnt))
      else $error("prescaler moved while disabled");

   chk_tick_wrap: assert property (
      tick && !clr |=> st_r.pre_cnt == 10'h000)
      else $error("prescaler did not wrap on tick");

   chk_div_write: assert property (
      wr_wdt |=> st_r.div_sel == $past(wr_data_in[`WDT_DIV_MSB:`WDT_DIV_LSB]))
      else $error("divider write not stored");

   chk_en_hold: assert property (
      !wr_wdt && !ovf && !st_r.chip_rst |=> $stable(st_r.wdt_en))
      else $error("enable changed without a write");

   chk_ale_write: assert property (
      wr_sys |=> st_r.ale_inh == $past(wr_data_in[`SYS_LATCH_STROBE_INHIBIT_BIT]))
      else $error("latch inhibit write not stored");

   chk_ale_toggle: assert property (
      !st_r.ale_inh && st_r.ale_div == `ALE_HALF_LAST |=> ale_out != $past(ale_out))
      else $error("latch clock did not toggle");

   chk_isp_hold: assert property (
      !wr_sys |=> $stable(isp_enable_out))
      else $error("isp enable changed without a write");

   chk_rd_idle: assert property (
      !rd_strobe_in |=> rd_data_out == 8'h00)
      else $error("read data stands without a read");

   chk_sys_unused: assert property (
      rd_strobe_in && addr_in == `SYS_CTL_ADDR |=> rd_data_out[6:3] == 4'h0
         && !rd_data_out[1])
      else $error("unused system bits read nonzero");

   chk_unmapped_zero: assert property (
      rd_strobe_in && addr_in != `WDT_CTL_ADDR && addr_in != `SYS_CTL_ADDR
         && addr_in != `IRQ_STAT_ADDR && addr_in != `IRQ_MASK_ADDR
         |=> rd_data_out == 8'h00)
      else $error("unmapped read returned data");

   chk_rd_wdt_data: assert property (
      rd_strobe_in && addr_in == `WDT_CTL_ADDR |=> rd_data_out[7] == $past(st_r.wdt_en)
         && rd_data_out[2:0] == $past(st_r.div_sel))
      else $error("control read data wrong");

   chk_rd_sys_data: assert property (
      rd_strobe_in && addr_in == `SYS_CTL_ADDR |=> rd_data_out[7] == $past(st_r.wdt_flag)
         && rd_data_out[2] == $past(st_r.isp_en) && rd_data_out[0] == $past(st_r.ale_inh))
      else $error("system control read data wrong");

   cov_overflow: cover property (ovf ##1 chip_reset_out);
   cov_clear_kick: cover property (st_r.wdt_en && clr);
   cov_half_irq: cover property (half ##1 st_r.irq_stat[`IRQ_HALF_BIT]);
   cov_flag_read: cover property (rd_strobe_in && addr_in == `SYS_CTL_ADDR && st_r.wdt_flag);
   cov_div_max: cover property (wr_wdt && wr_data_in[2:0] == 3'h7 && wr_data_in[7]);

endmodule : watchdog_reset_timer

// File: tb_watchdog_reset_timer.sv
// Self-checking testbench for the watchdog reset timer
`timescale 1ns/10ps
`include "watchdog_regs.svh"
module tb_watchdog_reset_timer;
   import watchdog_pkg::*;
   // Short count keeps every timeout run brief
   localparam logic [15:0] CMAX = 16'h000F;
   logic       ref_clk_in   = 1'b0;
   logic       resetn_in    = 1'b0;
   logic [7:0] addr_in      = 8'h00;
   logic [7:0] wr_data_in   = 8'h00;
   logic       wr_strobe_in = 1'b0;
   logic       rd_strobe_in = 1'b0;
   logic [7:0] rd_data_out;
   logic       chip_reset_out;
   logic       ale_out;
   logic       isp_enable_out;
   logic       irq_out;
   int         n_mismatch   = 0;
   int         total_checks = 0;
   int         n;
   int         t;
   logic       flag;

   watchdog_reset_timer #(.CNT_MAX(CMAX)) uut (
      .ref_clk_in     (ref_clk_in),
      .resetn_in      (resetn_in),
      .addr_in        (addr_in),
      .wr_data_in     (wr_data_in),
      .wr_strobe_in   (wr_strobe_in),
      .rd_strobe_in   (rd_strobe_in),
      .rd_data_out    (rd_data_out),
      .chip_reset_out (chip_reset_out),
      .ale_out        (ale_out),
      .isp_enable_out (isp_enable_out),
      .irq_out        (irq_out)
   );

   always #50 ref_clk_in = ~ref_clk_in;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk_in);
      addr_in      <= a;
      wr_data_in   <= v;
      wr_strobe_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_strobe_in <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe edge
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk_in);
      addr_in      <= a;
      rd_strobe_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_strobe_in <= 1'b0;
      #1;
      chk(rd_data_out, exp);
   endtask : rdchk

   // Counts edges from the taking edge of the last write until the reset pulse
   task automatic run_to_reset(input int lim, output int cnt);
      cnt = 0;
      while (cnt < lim) begin
         @(posedge ref_clk_in);
         cnt++;
         #1;
         if (chip_reset_out === 1'b1) break;
      end
      // Enable writes are ignored while the pulse stands
      repeat (8) @(posedge ref_clk_in);
   endtask : run_to_reset

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   initial begin
      #(60_000 * 100);
      n_mismatch++;
      close_out();
   end

   initial begin
      repeat (8) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      rdchk(8'h9F, 8'h00);
      rdchk(8'hBF, 8'h00);
      wr(8'hBF, 8'hFF);
      rdchk(8'hBF, 8'h05);
      chk({7'h0, isp_enable_out}, 8'h01);
      flag = 1'b0;
      repeat (12) begin
         @(posedge ref_clk_in);
         #1 flag = flag | (ale_out !== 1'b0);
      end
      chk({7'h0, flag}, 8'h00);
      wr(8'hBF, 8'h00);
      flag = 1'b0;
      repeat (10) begin
         @(posedge ref_clk_in);
         #1 flag = flag | (ale_out === 1'b1);
      end
      chk({7'h0, flag}, 8'h01);
      chk({7'h0, isp_enable_out}, 8'h00);
      wr(8'h55, 8'hFF);
      rdchk(8'h55, 8'h00);
      wr(8'h9F, 8'hFF);
      rdchk(8'h9F, 8'h87);
      wr(8'h9F, 8'h00);
      // A kick late in the period must restart a full timeout
      t = (int'(CMAX) + 1) * 8;
      wr(8'h9F, 8'hA0);
      repeat (100) @(posedge ref_clk_in);
      wr(8'h9F, 8'hA0);
      run_to_reset(400, n);
      chk({7'h0, (n == t || n == t + 1)}, 8'h01);
      rdchk(8'h9F, 8'h00);
      rdchk(8'hBF, 8'h80);
      chk({7'h0, irq_out}, 8'h00);
      wr(8'hE2, 8'h01);
      repeat (2) @(posedge ref_clk_in);
      chk({7'h0, irq_out}, 8'h01);
      rdchk(8'hE1, 8'h03);
      repeat (2) @(posedge ref_clk_in);
      chk({7'h0, irq_out}, 8'h00);
      rdchk(8'hE1, 8'h00);
      wr(8'hBF, 8'h80);
      rdchk(8'hBF, 8'h80);
      wr(8'hBF, 8'h00);
      rdchk(8'hBF, 8'h00);
      for (int dv = 0; dv < 8; dv++) begin
         t = (int'(CMAX) + 1) * (8 << dv);
         wr(8'h9F, 8'hA0 | 8'(dv));
         run_to_reset(20_000, n);
         chk({7'h0, (n == t || n == t + 1)}, 8'h01);
         rdchk(8'h9F, 8'(dv));
         rdchk(8'hBF, 8'h80);
      end
      close_out();
   end
endmodule : tb_watchdog_reset_timer
